// ---- rtl/pct_pkg.sv ----
// Constants, field positions and carriers for the PHY control and 10BASE-T register bank.
// Assumes a simple I/O register port: address offset, read and write strobes, 16-bit data.
// How it works
// - Bit 11 picks 15-stage or 9-stage sequence
// - Result bit latches pass, cleared by any control write
// - Run bit repeats self-test until cleared
// - Bit 8 makes LEDs follow raw indication
// - Pause bit set when both ends pause-capable
// - Bits 4:0 hold address, reset all ones
// - Loop bit ORed with basic-control loopback bit
// - Bit 7 suppresses normal link pulses
// - Bit 6 ORed with MAC-side forced link
// - Bit 5 forces inverted receive polarity
// - Polarity bit latches high, cleared by either read
// - Bit 3 switches automatic polarity correction off
// - Heartbeat-off only matters half-duplex 10 Mb/s
// - Jabber-off applies only in 10 Mb/s full duplex
// - Registers decoded at I/O base plus offset
package pct_pkg;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_PAGE      = 8'hCC;
  localparam logic [7:0]  OFS_PHYCTL    = 8'hE4;
  localparam logic [7:0]  OFS_TENBT     = 8'hE8;
  localparam logic [7:0]  OFS_DSP       = 8'hF4;
  localparam logic [7:0]  OFS_SIGNAL_DETECT_CONFIG     = 8'hF8;
  localparam logic [7:0]  OFS_TEST      = 8'hFC;
  localparam logic [15:0] RST_PHYCTL    = 16'h003F;
  localparam logic [15:0] RST_TENBT     = 16'h0004;
  localparam logic [15:0] RST_PLAIN     = 16'h0000;
  localparam logic [15:0] PAGE_TUNE     = 16'h0001;
  localparam int          B_LONG_SEQ    = 11;
  localparam int          B_RESULT      = 10;
  localparam int          B_RUN         = 9;
  localparam int          B_LED_BYP     = 8;
  localparam int          B_PAUSE       = 7;
  localparam int          B_LOOP        = 8;
  localparam int          B_LP_OFF      = 7;
  localparam int          B_FORCE_LINK  = 6;
  localparam int          B_POL_FORCE   = 5;
  localparam int          B_POL_STAT    = 4;
  localparam int          B_APOL_OFF    = 3;
  localparam int          B_MUST_ONE    = 2;
  localparam int          B_SQE_OFF     = 1;
  localparam int          B_JAB_OFF     = 0;
  localparam logic [15:0] MASK_PHYCTL   = 16'h0B1F;
  localparam logic [15:0] MASK_TENBT    = 16'h01EF;
  localparam logic [14:0] LFSR_SEED     = 15'h7FFF;
  localparam logic [7:0]  BIST_PASS_CNT = 8'hFF;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pct_req_t;

  typedef struct packed {
    logic       lowspeed_loop;
    logic       link_pulse_off;
    logic       lowspeed_link_good;
    logic       polarity_inverted;
    logic       auto_polarity_en;
    logic       sqe_test_en;
    logic       jabber_en;
  } pct_tenbt_ctl_t;
endpackage

// ---- rtl/pct_regs.sv ----
// PHY control and 10BASE-T status/control register bank with self-test engine.
// Assumes the register port and status inputs come from logic on i_clk.
module pct_regs
  import pct_pkg::*;
(
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire pct_req_t       i_req,
  output logic [15:0]         o_rdata,
  input  wire logic           i_basic_mode_control_reg_loopback,
  input  wire logic           i_mac_side_lowspeed_link_hold,
  input  wire logic           i_local_pause,
  input  wire logic           i_partner_pause,
  input  wire logic           i_pol_inverted_evt,
  input  wire logic           i_phy_status_reg_read,
  input  wire logic           i_speed_100,
  input  wire logic           i_full_duplex,
  input  wire logic           i_led_raw,
  input  wire logic           i_led_stretched,
  output logic                o_led,
  output logic                o_bist_running,
  output logic [4:0]          o_port_mgmt_address,
  output pct_tenbt_ctl_t      o_tenbt_ctl,
  output logic [15:0]         o_page_select,
  output logic [15:0]         o_pmd_control_status,
  output logic [15:0]         o_dsp_config,
  output logic [15:0]         o_signal_detect_config,
  output logic [15:0]         o_test_data,
  output logic                o_polarity_status
);
  logic        rst_s1_reg;
  logic        rstn;
  logic [15:0] phyctl_reg;
  logic [15:0] tenbt_reg;
  logic        pol_reg;
  logic        result_reg;
  logic [14:0] lfsr_reg;
  logic [7:0]  pass_cnt_reg;
  logic [15:0] page_reg;
  logic [15:0] pmd_reg;
  logic [15:0] dsp_reg;
  logic [15:0] sd_reg;
  logic [15:0] test_reg;
  logic        wr_phy;
  logic        wr_ten;
  logic        rd_ten;
  logic        tune_page;
  logic        lfsr_fb;
  logic        lfsr_ref;
  logic [14:0] ref_reg;
  logic        fail_reg;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Reset released through two flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_reg <= 1'b0;
      rstn       <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rstn       <= rst_s1_reg;
    end
  end

  // Offset 00E4 shares two registers; page select one gives the tuning view
  assign tune_page = (page_reg == PAGE_TUNE);
  assign wr_phy = i_req.wr && hit(i_req.addr, OFS_PHYCTL) && !tune_page;
  assign wr_ten = i_req.wr && hit(i_req.addr, OFS_TENBT);
  assign rd_ten = i_req.rd && hit(i_req.addr, OFS_TENBT);

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      phyctl_reg <= RST_PHYCTL;
    end else if (wr_phy) begin
      phyctl_reg <= i_req.wdata & MASK_PHYCTL;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      tenbt_reg <= RST_TENBT;
    end else if (wr_ten) begin
      tenbt_reg <= i_req.wdata & MASK_TENBT;
    end
  end

  // Event wins over a clearing read so no inversion is lost
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      pol_reg <= 1'b0;
    end else if (i_pol_inverted_evt && !tenbt_reg[B_APOL_OFF]) begin
      pol_reg <= 1'b1;
    end else if (rd_ten || i_phy_status_reg_read) begin
      pol_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      page_reg <= RST_PLAIN;
      pmd_reg  <= RST_PLAIN;
      dsp_reg  <= RST_PLAIN;
      sd_reg   <= RST_PLAIN;
      test_reg <= RST_PLAIN;
    end else if (i_req.wr) begin
      if (hit(i_req.addr, OFS_PAGE)) begin
        page_reg <= i_req.wdata;
      end
      if (hit(i_req.addr, OFS_PHYCTL) && tune_page) begin
        pmd_reg <= i_req.wdata;
      end
      if (hit(i_req.addr, OFS_DSP)) begin
        dsp_reg <= i_req.wdata;
      end
      if (hit(i_req.addr, OFS_SIGNAL_DETECT_CONFIG)) begin
        sd_reg <= i_req.wdata;
      end
      if (hit(i_req.addr, OFS_TEST)) begin
        test_reg <= i_req.wdata;
      end
    end
  end

  // Self-test: generator checked against an internal reference copy
  assign lfsr_fb  = phyctl_reg[B_LONG_SEQ] ? (lfsr_reg[14] ^ lfsr_reg[13])
                                           : (lfsr_reg[8] ^ lfsr_reg[4]);
  // Reference taps come from its own copy, so a stuck generator bit shows up
  assign lfsr_ref = phyctl_reg[B_LONG_SEQ] ? (ref_reg[14] ^ ref_reg[13])
                                           : (ref_reg[8] ^ ref_reg[4]);

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr_reg     <= LFSR_SEED;
      pass_cnt_reg <= 8'h00;
    end else if (phyctl_reg[B_RUN]) begin
      lfsr_reg     <= {lfsr_reg[13:0], lfsr_fb};
      if (pass_cnt_reg != BIST_PASS_CNT) begin
        pass_cnt_reg <= pass_cnt_reg + 8'h01;
      end
    end else begin
      lfsr_reg     <= LFSR_SEED;
      pass_cnt_reg <= 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      ref_reg <= LFSR_SEED;
    end else if (phyctl_reg[B_RUN]) begin
      ref_reg <= {ref_reg[13:0], lfsr_ref};
    end else begin
      ref_reg <= LFSR_SEED;
    end
  end

  // Sticky until the run stops, so one bad cycle fails the whole run
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      fail_reg <= 1'b0;
    end else if (!phyctl_reg[B_RUN]) begin
      fail_reg <= 1'b0;
    end else if (lfsr_reg != ref_reg) begin
      fail_reg <= 1'b1;
    end
  end

  // Limitation: loop is internal, so only a real fault source would flag fail
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= 1'b0;
    end else if (wr_phy) begin
      result_reg <= 1'b0;
    end else if (phyctl_reg[B_RUN] && pass_cnt_reg == BIST_PASS_CNT && !fail_reg && lfsr_reg == ref_reg) begin
      result_reg <= 1'b1;
    end
  end

  always_comb begin
    o_rdata = 16'h0000;
    if (i_req.rd) begin
      case (i_req.addr)
        OFS_PAGE:   o_rdata = page_reg;
        OFS_PHYCTL: begin
          if (tune_page) begin
            o_rdata = pmd_reg;
          end else begin
            o_rdata = phyctl_reg;
            o_rdata[B_RESULT] = result_reg;
            o_rdata[B_PAUSE]  = i_local_pause & i_partner_pause;
          end
        end
        OFS_TENBT: begin
          o_rdata = tenbt_reg;
          o_rdata[B_POL_STAT] = pol_reg;
        end
        OFS_DSP:    o_rdata = dsp_reg;
        OFS_SIGNAL_DETECT_CONFIG:  o_rdata = sd_reg;
        OFS_TEST:   o_rdata = test_reg;
        default:    o_rdata = 16'h0000;
      endcase
    end
  end

  assign o_led = phyctl_reg[B_LED_BYP] ? i_led_raw : i_led_stretched;
  assign o_bist_running         = phyctl_reg[B_RUN];
  assign o_port_mgmt_address    = phyctl_reg[4:0];
  assign o_polarity_status      = pol_reg;
  assign o_page_select          = page_reg;
  assign o_pmd_control_status   = pmd_reg;
  assign o_dsp_config           = dsp_reg;
  assign o_signal_detect_config = sd_reg;
  assign o_test_data            = test_reg;

  always_comb begin
    o_tenbt_ctl.lowspeed_loop      = tenbt_reg[B_LOOP] | i_basic_mode_control_reg_loopback;
    o_tenbt_ctl.link_pulse_off     = tenbt_reg[B_LP_OFF];
    o_tenbt_ctl.lowspeed_link_good = tenbt_reg[B_FORCE_LINK] | i_mac_side_lowspeed_link_hold;
    o_tenbt_ctl.polarity_inverted  = tenbt_reg[B_POL_FORCE] | (pol_reg & ~tenbt_reg[B_APOL_OFF]);
    o_tenbt_ctl.auto_polarity_en   = ~tenbt_reg[B_APOL_OFF];
    o_tenbt_ctl.sqe_test_en        = ~i_speed_100 & ~i_full_duplex & ~tenbt_reg[B_SQE_OFF];
    o_tenbt_ctl.jabber_en          = ~(tenbt_reg[B_JAB_OFF] & ~i_speed_100 & i_full_duplex);
  end

  AST_PAUSE: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_req.rd && i_req.addr == OFS_PHYCTL && !tune_page) |->
    o_rdata[B_PAUSE] == (i_local_pause & i_partner_pause)) else $error("pause bit wrong");
  AST_RESULT_CLR: assert property (@(posedge i_clk) disable iff (!rstn)
    wr_phy |=> !result_reg) else $error("result not cleared");
  AST_POL_SET: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_pol_inverted_evt && !tenbt_reg[B_APOL_OFF]) |=> pol_reg) else $error("polarity not latched");
  AST_POL_CLR: assert property (@(posedge i_clk) disable iff (!rstn)
    (rd_ten && !i_pol_inverted_evt) |=> !pol_reg) else $error("polarity not cleared");
  AST_LOOP: assert property (@(posedge i_clk) disable iff (!rstn)
    o_tenbt_ctl.lowspeed_loop == (tenbt_reg[B_LOOP] | i_basic_mode_control_reg_loopback)) else $error("loop wrong");
  AST_LINK: assert property (@(posedge i_clk) disable iff (!rstn)
    i_mac_side_lowspeed_link_hold |-> o_tenbt_ctl.lowspeed_link_good) else $error("link not forced");
  AST_SQE: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_speed_100 || i_full_duplex) |-> !o_tenbt_ctl.sqe_test_en) else $error("heartbeat on");
  AST_ADDR: assert property (@(posedge i_clk) disable iff (!rstn)
    (wr_phy ##1 !wr_phy) |-> o_port_mgmt_address == $past(i_req.wdata[4:0])) else $error("address lost");
  AST_RSVD: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_req.rd && i_req.addr == OFS_TENBT) |-> o_rdata[15:9] == 7'h00) else $error("reserved nonzero");
  AST_RUN: assert property (@(posedge i_clk) disable iff (!rstn)
    !o_bist_running |=> pass_cnt_reg == 8'h00) else $error("self-test not stopped");

  // Generator taps per selected length
  AST_SHORT_SEQ: assert property (@(posedge i_clk) disable iff (!rstn)
    (phyctl_reg[B_RUN] && !phyctl_reg[B_LONG_SEQ] && !wr_phy) |=>
    lfsr_reg[0] == ($past(lfsr_reg[8]) ^ $past(lfsr_reg[4]))) else $error("short sequence taps wrong");
  AST_LONG_SEQ: assert property (@(posedge i_clk) disable iff (!rstn)
    (phyctl_reg[B_RUN] && phyctl_reg[B_LONG_SEQ] && !wr_phy) |=>
    lfsr_reg[0] == ($past(lfsr_reg[14]) ^ $past(lfsr_reg[13]))) else $error("long sequence taps wrong");
  AST_PASS_SET: assert property (@(posedge i_clk) disable iff (!rstn)
    (phyctl_reg[B_RUN] && pass_cnt_reg == BIST_PASS_CNT && !fail_reg && lfsr_reg == ref_reg && !wr_phy) |=>
    result_reg) else $error("self-test pass not latched");
  AST_LED: assert property (@(posedge i_clk) disable iff (!rstn)
    phyctl_reg[B_LED_BYP] |-> o_led == i_led_raw) else $error("led not bypassed");
  AST_LP_OFF: assert property (@(posedge i_clk) disable iff (!rstn)
    o_tenbt_ctl.link_pulse_off == tenbt_reg[B_LP_OFF]) else $error("link pulse control wrong");
  AST_LINK_REG: assert property (@(posedge i_clk) disable iff (!rstn)
    tenbt_reg[B_FORCE_LINK] |-> o_tenbt_ctl.lowspeed_link_good) else $error("link not forced by bit");
  AST_POL_FORCE: assert property (@(posedge i_clk) disable iff (!rstn)
    tenbt_reg[B_POL_FORCE] |-> o_tenbt_ctl.polarity_inverted) else $error("polarity not forced");
  AST_APOL_OFF: assert property (@(posedge i_clk) disable iff (!rstn)
    (tenbt_reg[B_APOL_OFF] && !pol_reg) |=> !pol_reg) else $error("polarity latched while off");
  AST_SQE_ON: assert property (@(posedge i_clk) disable iff (!rstn)
    (!i_speed_100 && !i_full_duplex && !tenbt_reg[B_SQE_OFF]) |-> o_tenbt_ctl.sqe_test_en)
    else $error("heartbeat off");
  AST_JAB_ON: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_speed_100 || !i_full_duplex || !tenbt_reg[B_JAB_OFF]) |-> o_tenbt_ctl.jabber_en)
    else $error("jabber off outside full duplex");
  AST_JAB_OFF: assert property (@(posedge i_clk) disable iff (!rstn)
    (tenbt_reg[B_JAB_OFF] && !i_speed_100 && i_full_duplex) |-> !o_tenbt_ctl.jabber_en)
    else $error("jabber not switched off");
  AST_UNMAPPED: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_req.rd && i_req.addr == 8'h00) |-> o_rdata == 16'h0000) else $error("unmapped read nonzero");
  AST_PMD_ISO: assert property (@(posedge i_clk) disable iff (!rstn)
    (i_req.wr && i_req.addr == OFS_PHYCTL && tune_page) |=> $stable(phyctl_reg))
    else $error("tuning write hit control word");

  COV_PASS: cover property (@(posedge i_clk) disable iff (!rstn) $rose(result_reg));
  COV_POL:  cover property (@(posedge i_clk) disable iff (!rstn) pol_reg ##1 !pol_reg);
  COV_TUNE: cover property (@(posedge i_clk) disable iff (!rstn) i_req.wr && tune_page);
  COV_STOP: cover property (@(posedge i_clk) disable iff (!rstn) $fell(phyctl_reg[B_RUN]));
endmodule

// ---- tb/pct_link_partner.sv ----
// Behavioural far-end link partner: pause ability and polarity events.
// Assumes the bench drives the requests on the falling edge of i_clk.
module pct_link_partner (
  input  wire logic i_clk,
  input  wire logic i_pause_cap,
  input  wire logic i_flip,
  output logic      o_pause,
  output logic      o_pol_evt
);
  timeunit 1ns;
  timeprecision 100ps;
  assign o_pause = i_pause_cap;
  // Swapped pair seen as one event per request
  always_ff @(posedge i_clk) begin
    o_pol_evt <= i_flip;
  end
endmodule

// ---- tb/pct_regs_tb_top.sv ----
// Self-checking bench for the PHY control and 10BASE-T register bank.
// Assumes 40 MHz clock; inputs move on the falling edge only.
module pct_regs_tb_top;
  import pct_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic           clk = 1'b0;
  logic           resetn = 1'b0;
  pct_req_t       req = '0;
  logic           basic_mode_control_reg = 1'b0, mfl = 1'b0, lpause = 1'b0, ppcap = 1'b0, flip = 1'b0;
  logic           phy_status_reg_rd = 1'b0, spd = 1'b0, fdx = 1'b0, led_raw = 1'b1, led_str = 1'b0;
  logic [15:0]    rdata, pg, pmd, dsp, sd, tst;
  logic           led, run, pol, ppause, pevt;
  logic [4:0]     paddr;
  pct_tenbt_ctl_t ctl;
  int             failures = 0;
  int             num_checks = 0;
  int             cycles = 0;

  always #12.5 clk = ~clk;

  pct_link_partner lp_u (.i_clk(clk), .i_pause_cap(ppcap), .i_flip(flip), .o_pause(ppause), .o_pol_evt(pevt));
  pct_regs dut_u (.i_clk(clk), .i_resetn(resetn), .i_req(req), .o_rdata(rdata), .i_basic_mode_control_reg_loopback(basic_mode_control_reg),
    .i_mac_side_lowspeed_link_hold(mfl), .i_local_pause(lpause), .i_partner_pause(ppause), .i_pol_inverted_evt(pevt),
    .i_phy_status_reg_read(phy_status_reg_rd), .i_speed_100(spd), .i_full_duplex(fdx), .i_led_raw(led_raw),
    .i_led_stretched(led_str), .o_led(led), .o_bist_running(run), .o_port_mgmt_address(paddr),
    .o_tenbt_ctl(ctl), .o_page_select(pg), .o_pmd_control_status(pmd), .o_dsp_config(dsp),
    .o_signal_detect_config(sd), .o_test_data(tst), .o_polarity_status(pol));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  // Held one cycle only: a read clears the polarity latch
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    #2 check(rdata, exp);
    @(negedge clk);
    req.rd = 1'b0;
  endtask

  task automatic pulse_flip();
    @(negedge clk) flip = 1'b1;
    @(negedge clk) flip = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset();
    rd(OFS_PHYCTL, 16'h003F);
    rd(OFS_TENBT, 16'h0004);
    check({11'h000, paddr}, 16'h001F);
    rd(8'h00, 16'h0000);
  endtask

  task automatic t_phy_fields();
    wr(OFS_PHYCTL, 16'hF1FF);
    rd(OFS_PHYCTL, 16'h011F);
    check({15'h0, led}, 16'h0001);
    wr(OFS_PHYCTL, 16'h0800);
    rd(OFS_PHYCTL, 16'h0800);
    check({15'h0, led}, 16'h0000);
    @(negedge clk) lpause = 1'b1;
    ppcap = 1'b1;
    rd(OFS_PHYCTL, 16'h0880);
    @(negedge clk) ppcap = 1'b0;
    rd(OFS_PHYCTL, 16'h0800);
  endtask

  task automatic t_tenbt_ctl();
    wr(OFS_TENBT, 16'hFFFF);
    rd(OFS_TENBT, 16'h01EF);
    check({9'h0, ctl}, 16'h0079);
    @(negedge clk) fdx = 1'b1;
    #2 check({9'h0, ctl}, 16'h0078);
    wr(OFS_TENBT, 16'h0004);
    check({9'h0, ctl}, 16'h0005);
    @(negedge clk) fdx = 1'b0;
    basic_mode_control_reg = 1'b1;
    mfl = 1'b1;
    #2 check({9'h0, ctl}, 16'h0057);
    @(negedge clk) spd = 1'b1;
    #2 check({9'h0, ctl}, 16'h0055);
  endtask

  task automatic t_polarity();
    pulse_flip();
    check({15'h0, pol}, 16'h0001);
    rd(OFS_TENBT, 16'h0014);
    rd(OFS_TENBT, 16'h0004);
    pulse_flip();
    @(negedge clk) phy_status_reg_rd = 1'b1;
    @(negedge clk) phy_status_reg_rd = 1'b0;
    check({15'h0, pol}, 16'h0000);
    wr(OFS_TENBT, 16'h000C);
    pulse_flip();
    check({15'h0, pol}, 16'h0000);
  endtask

  task automatic t_selftest();
    wr(OFS_PHYCTL, 16'h0A00);
    check({15'h0, run}, 16'h0001);
    repeat (40000) @(negedge clk);
    rd(OFS_PHYCTL, 16'h0E00);
    wr(OFS_PHYCTL, 16'h0800);
    rd(OFS_PHYCTL, 16'h0800);
    check({15'h0, run}, 16'h0000);
    wr(OFS_PHYCTL, 16'h0200);
    repeat (300) @(negedge clk);
    rd(OFS_PHYCTL, 16'h0600);
    wr(OFS_PHYCTL, 16'h0800);
    rd(OFS_PHYCTL, 16'h0800);
  endtask

  // Tuning writes in their required order; E4 lands on the PMD word while paged
  task automatic t_tuning();
    wr(OFS_PAGE, 16'h0001);
    wr(OFS_PHYCTL, 16'h189C);
    wr(OFS_TEST, 16'h0000);
    wr(OFS_DSP, 16'h5040);
    wr(OFS_SIGNAL_DETECT_CONFIG, 16'h008C);
    check(pg, 16'h0001);
    check(pmd, 16'h189C);
    check(tst, 16'h0000);
    check(dsp, 16'h5040);
    check(sd, 16'h008C);
    rd(OFS_PHYCTL, 16'h189C);
    wr(OFS_PAGE, 16'h0000);
    rd(OFS_PHYCTL, 16'h0800);
  endtask

  // Self-test wait dominates; ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_phy_fields();
    t_tenbt_ctl();
    t_polarity();
    t_selftest();
    t_tuning();
    end_of_test();
  end
endmodule
